// file: common/pcs_pkg.sv
package pcs_pkg;
  // counter and data widths
  localparam int PC_W = 13;
  localparam int TGT_W = 11;
  localparam int LATH_W = 5;
  localparam int STK_DEPTH = 8;
  localparam int STK_PTR_W = 3;
  localparam int DM_ADDR_W = 9;
  // register indices; byte address on the bus is four times the index
  localparam logic [6:0] IDX_IND = 7'h00;
  localparam logic [6:0] IDX_LOW = 7'h02;
  localparam logic [6:0] IDX_FSEL = 7'h04;
  localparam logic [6:0] IDX_LATH = 7'h0A;
  // reset values
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [4:0] LATH_RST = 5'h00;
  localparam logic [7:0] FSEL_RST = 8'h00;
  localparam logic [2:0] STK_PTR_RST = 3'h0;
  // interrupt entry address
  localparam logic [12:0] INT_VECTOR = 13'h0004;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // program-flow step requested by the decoder
  typedef enum logic [2:0] {
    OP_NONE,
    OP_STEP,
    OP_JUMP,
    OP_CALL,
    OP_RET,
    OP_EXIT_LIT,
    OP_EXIT_INT,
    OP_INT
  } pcs_op_t;
endpackage : pcs_pkg

// file: design/pcs_indirect.sv
`timescale 1ns/1ps
module pcs_indirect
  import pcs_pkg::*;
(
  input wire logic [6:0] fa_addr, // register address inside a bank
  input wire logic [7:0] fsel, // file select pointer
  input wire logic bank_bit, // indirect bank bit
  output logic ind_hit, // access names the indirect port
  output logic ind_self, // pointer aims back at the port
  output logic [8:0] ind_addr // effective data address
);
  // the port has no storage; the pointer picks the real location
  assign ind_hit = (fa_addr == IDX_IND);
  // both bank images of the port count as a self reference
  assign ind_self = (fsel[6:0] == IDX_IND);
  assign ind_addr = {bank_bit, fsel};
endmodule : pcs_indirect

// file: design/pcs_ret_stack.sv
`timescale 1ns/1ps
module pcs_ret_stack
  import pcs_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic resetn, // async reset, active low
  input wire logic clk_en, // freezes state when low
  input wire logic push, // store push_pc on top
  input wire logic pop, // drop the top entry
  input wire logic [12:0] push_pc, // return address to store
  output logic [12:0] top_pc // most recent entry
);
  logic [2:0] ptr_q;
  logic [12:0] ent_q [STK_DEPTH];

  // pointer wraps freely; no overflow or underflow flag exists
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      ptr_q <= STK_PTR_RST;
    else if (clk_en && push)
      ptr_q <= ptr_q + 3'h1;
    else if (clk_en && pop)
      ptr_q <= ptr_q - 3'h1;
  end

  // one entry register per level; ninth push lands on the first slot
  for (genvar i = 0; i < STK_DEPTH; i++)
  begin : g_ent
    always_ff @(posedge core_clk or negedge resetn)
    begin
      if (!resetn)
        ent_q[i] <= PC_RST;
      else if (clk_en && push && ptr_q == 3'(i))
        ent_q[i] <= push_pc;
    end
  end

  assign top_pc = ent_q[ptr_q - 3'h1];

  chk_ptr_wrap: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && push && ptr_q == 3'h7) |=> ptr_q == 3'h0)
    else $error("stack pointer did not wrap");
  chk_push_top: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && push) |=> top_pc == $past(push_pc))
    else $error("pushed value not on top");
endmodule : pcs_ret_stack

// file: design/pcs_top.sv
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Operation
// - keep a 13-bit counter; low byte readable and writable as a register
// - upper counter bits never read or written directly; low-byte writes load them from the latch
// - any reset clears the whole counter to zero
// - writing the low byte also loads latch bits 4..0 into the upper bits
// - jump or call takes only latch bits 4 and 3 into the top bits
// - eight-level, 13-bit return stack with an unreachable pointer
// - push the next address on a call, or the counter on an interrupt vector branch
// - pop into the counter on return, literal return or interrupt return
// - pushes and pops leave the upper-bits latch untouched
// - stack is circular; ninth push overwrites the first entry
// - no overflow or underflow indication of any kind
// - accesses to the indirect port go to the location the pointer selects
// - reading the port through a self-pointing pointer returns zero
// - writing the port through a self-pointing pointer is discarded
// - effective address is bank bit above the 8-bit pointer; bank bit unused
module pcs_top
  import pcs_pkg::*;
(
  input wire logic core_clk, // core clock, 10 MHz
  input wire logic resetn, // async reset, active low
  input wire logic clk_en, // freezes all state when low
  input wire pcs_op_t op_kind, // program-flow step this cycle
  input wire logic [10:0] op_target, // jump or call target literal
  input wire logic fa_valid, // core register access request
  input wire logic fa_write, // access is a write
  input wire logic [6:0] fa_addr, // register address inside a bank
  input wire logic [7:0] fa_wdata, // core write data
  output logic fa_rvalid, // core read answer strobe
  output logic [7:0] fa_rdata, // core read answer
  output logic [12:0] pc_out, // fetch address
  output logic dm_en, // data memory access strobe
  output logic dm_we, // data memory write
  output logic [8:0] dm_addr, // data memory address
  output logic [7:0] dm_wdata, // data memory write data
  input wire logic [7:0] dm_rdata, // data memory read data, same cycle
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  logic [12:0] pc_q, stk_top, push_pc;
  logic [4:0] lath_q;
  logic [7:0] fsel_q, aw_addr_q, rd_val_q, fa_rdata_q, dm_wdata_q;
  logic [8:0] ind_addr, dm_addr_q;
  logic [5:0] ax_widx, ax_ridx;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic stk_push, stk_pop, ind_hit, ind_self, fa_low_wr, fa_lath_wr, fa_fsel_wr, fa_rd;
  logic ax_fire, ax_low_wr, ax_lath_wr, ax_fsel_wr, ax_wmapped, aw_hold_q, w_hold_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, rd_pend_q, rd_mem_q;
  logic fa_rvalid_q, dm_en_q, dm_we_q;
  // core register decode; bank bits are already stripped by the decoder
  assign fa_low_wr = fa_valid && fa_write && (fa_addr == IDX_LOW);
  assign fa_lath_wr = fa_valid && fa_write && (fa_addr == IDX_LATH);
  assign fa_fsel_wr = fa_valid && fa_write && (fa_addr == IDX_FSEL);
  assign fa_rd = fa_valid && !fa_write;
  // bus write decode, applied once both halves are held
  assign ax_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign ax_widx = aw_addr_q[7:2];
  assign ax_wmapped = (ax_widx == IDX_LOW[5:0]) || (ax_widx == IDX_LATH[5:0])
    || (ax_widx == IDX_FSEL[5:0]);
  assign ax_low_wr = ax_fire && w_strb_q[0] && (ax_widx == IDX_LOW[5:0]);
  assign ax_lath_wr = ax_fire && w_strb_q[0] && (ax_widx == IDX_LATH[5:0]);
  assign ax_fsel_wr = ax_fire && w_strb_q[0] && (ax_widx == IDX_FSEL[5:0]);
  assign ax_ridx = s_axi_araddr[7:2];
  // stack control; a call saves the next address, an interrupt the current one
  assign stk_push = clk_en && (op_kind == OP_CALL || op_kind == OP_INT);
  assign stk_pop = clk_en && (op_kind == OP_RET || op_kind == OP_EXIT_LIT
    || op_kind == OP_EXIT_INT);
  assign push_pc = (op_kind == OP_CALL) ? pc_q + 13'h0001 : pc_q;
  pcs_ret_stack u_stack (
    .core_clk (core_clk),
    .resetn (resetn),
    .clk_en (clk_en),
    .push (stk_push),
    .pop (stk_pop),
    .push_pc (push_pc),
    .top_pc (stk_top)
  );
  // bank bit is held low: this family has no second indirect bank
  pcs_indirect u_indirect (
    .fa_addr (fa_addr),
    .fsel (fsel_q),
    .bank_bit (1'b0),
    .ind_hit (ind_hit),
    .ind_self (ind_self),
    .ind_addr (ind_addr)
  );
  // program counter; a low-byte write overrides the step of the same cycle
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pc_q <= PC_RST;
    else if (clk_en)
    begin
      if (fa_low_wr)
        pc_q <= {lath_q, fa_wdata};
      else if (ax_low_wr)
        pc_q <= {lath_q, w_data_q[7:0]};
      else
      begin
        case (op_kind)
          OP_STEP: pc_q <= pc_q + 13'h0001;
          OP_JUMP, OP_CALL: pc_q <= {lath_q[4:3], op_target};
          OP_RET, OP_EXIT_LIT, OP_EXIT_INT: pc_q <= stk_top;
          OP_INT: pc_q <= INT_VECTOR;
          default: pc_q <= pc_q;
        endcase
      end
    end
  end
  // upper-bits latch; only register writes touch it, never the stack
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      lath_q <= LATH_RST;
    else if (clk_en && fa_lath_wr)
      lath_q <= fa_wdata[4:0];
    else if (clk_en && ax_lath_wr)
      lath_q <= w_data_q[4:0];
  end
  // file select pointer; core writes win over the bus
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      fsel_q <= FSEL_RST;
    else if (clk_en && fa_fsel_wr)
      fsel_q <= fa_wdata;
    else if (clk_en && ax_fsel_wr)
      fsel_q <= w_data_q[7:0];
  end
  // data memory port; a self-pointing access never reaches memory
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dm_en_q <= 1'b0;
      dm_we_q <= 1'b0;
      dm_addr_q <= 9'h000;
      dm_wdata_q <= 8'h00;
    end
    else if (clk_en)
    begin
      dm_en_q <= fa_valid && ind_hit && !ind_self;
      dm_we_q <= fa_valid && fa_write && ind_hit && !ind_self;
      dm_addr_q <= ind_addr;
      dm_wdata_q <= fa_wdata;
    end
  end
  // core reads, stage one: pick a value or mark a memory fetch
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_pend_q <= 1'b0;
      rd_mem_q <= 1'b0;
      rd_val_q <= 8'h00;
    end
    else if (clk_en)
    begin
      rd_pend_q <= fa_rd;
      rd_mem_q <= fa_rd && ind_hit && !ind_self;
      case (fa_addr)
        IDX_IND: rd_val_q <= 8'h00;
        IDX_LOW: rd_val_q <= pc_q[7:0];
        IDX_LATH: rd_val_q <= {3'h0, lath_q};
        IDX_FSEL: rd_val_q <= fsel_q;
        default: rd_val_q <= 8'h00;
      endcase
    end
  end
  // core reads, stage two: memory data is taken while dm_en is high
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fa_rvalid_q <= 1'b0;
      fa_rdata_q <= 8'h00;
    end
    else if (clk_en)
    begin
      fa_rvalid_q <= rd_pend_q;
      fa_rdata_q <= rd_mem_q ? dm_rdata : rd_val_q;
    end
  end
  // bus write address channel; ready stays low until the response is taken
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_hold_q <= 1'b0;
      awready_q <= 1'b1;
      aw_addr_q <= 8'h00;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && awready_q)
      begin
        aw_hold_q <= 1'b1;
        awready_q <= 1'b0;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (ax_fire)
        aw_hold_q <= 1'b0;
      else if (bvalid_q && s_axi_bready)
        awready_q <= 1'b1;
    end
  end
  // bus write data channel, independent of the address order
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      w_hold_q <= 1'b0;
      wready_q <= 1'b1;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else if (clk_en)
    begin
      if (s_axi_wvalid && wready_q)
      begin
        w_hold_q <= 1'b1;
        wready_q <= 1'b0;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      else if (ax_fire)
        w_hold_q <= 1'b0;
      else if (bvalid_q && s_axi_bready)
        wready_q <= 1'b1;
    end
  end
  // write response; unmapped or indirect index answers SLVERR
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (ax_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= ax_wmapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end
  // bus read; the indirect port needs the core's memory path, so it is refused
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && arready_q)
      begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rresp_q <= RESP_OKAY;
        case (ax_ridx)
          IDX_LOW[5:0]: rdata_q <= {24'h000000, pc_q[7:0]};
          IDX_LATH[5:0]: rdata_q <= {27'h0000000, lath_q};
          IDX_FSEL[5:0]: rdata_q <= {24'h000000, fsel_q};
          default:
          begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_SLVERR;
          end
        endcase
      end
      else if (rvalid_q && s_axi_rready)
      begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end
  // every output leaves straight from a register
  assign pc_out = pc_q;
  assign fa_rvalid = fa_rvalid_q;
  assign fa_rdata = fa_rdata_q;
  assign dm_en = dm_en_q;
  assign dm_we = dm_we_q;
  assign dm_addr = dm_addr_q;
  assign dm_wdata = dm_wdata_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  default clocking cb_core @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // steps of an indirect access as seen on the core port
  sequence s_ind_rd;
    clk_en && fa_rd && ind_hit && !ind_self;
  endsequence
  sequence s_self_rd;
    clk_en && fa_rd && ind_hit && ind_self;
  endsequence
  sequence s_step_hold;
    clk_en ##1 clk_en;
  endsequence

  chk_reset_clear: assert property (
    !$past(resetn) |-> pc_q == PC_RST)
    else $error("counter not zero after reset");
  chk_low_load: assert property (
    (clk_en && fa_low_wr) |=> pc_q == {$past(lath_q), $past(fa_wdata)})
    else $error("low byte write did not load latch bits");
  chk_jump_load: assert property (
    (clk_en && !fa_low_wr && !ax_low_wr && (op_kind == OP_JUMP || op_kind == OP_CALL))
    |=> pc_q == {$past(lath_q[4:3]), $past(op_target)})
    else $error("jump target formed wrongly");
  chk_step_inc: assert property (
    (clk_en && !fa_low_wr && !ax_low_wr && op_kind == OP_STEP)
    |=> pc_q == $past(pc_q) + 13'h0001)
    else $error("counter did not advance by one");
  chk_call_return: assert property (
    (clk_en && !fa_low_wr && !ax_low_wr && op_kind == OP_CALL)
    ##1 (clk_en && !fa_low_wr && !ax_low_wr && op_kind == OP_RET)
    |=> pc_q == $past(pc_q, 2) + 13'h0001)
    else $error("return did not restore caller");
  chk_latch_hold: assert property (
    ((stk_push || stk_pop) && !fa_lath_wr && !ax_lath_wr) |=> $stable(lath_q))
    else $error("latch changed by a stack action");
  chk_ind_fetch: assert property (
    s_ind_rd ##1 clk_en |-> (dm_en_q && !dm_we_q && dm_addr_q == {1'b0, $past(fsel_q)})
    ##1 (fa_rvalid_q && fa_rdata_q == $past(dm_rdata)))
    else $error("indirect read path wrong");
  chk_self_read: assert property (
    s_self_rd ##0 s_step_hold |-> !dm_en_q ##1 (fa_rvalid_q && fa_rdata_q == 8'h00))
    else $error("self-pointing read not zero");
  chk_self_write: assert property (
    (clk_en && fa_valid && fa_write && ind_hit && ind_self) |=> !dm_we_q && !dm_en_q)
    else $error("self-pointing write reached memory");
endmodule : pcs_top

// file: testbench/pcs_dmem_model.sv
`timescale 1ns/1ps
module pcs_dmem_model
(
  input wire logic core_clk, // core clock
  input wire logic dm_en, // access strobe
  input wire logic dm_we, // write strobe
  input wire logic [8:0] dm_addr, // byte address
  input wire logic [7:0] dm_wdata, // write data
  output logic [7:0] dm_rdata // read data, same cycle
);
  logic [7:0] mem [512];
  logic [7:0] idle_q;
  // zeroed store so first reads are defined
  initial
  begin
    for (int i = 0; i < 512; i++)
      mem[i] = 8'h00;
    idle_q = 8'h5A;
  end
  // store on a write strobe only
  always @(posedge core_clk)
  begin
    if (dm_en && dm_we)
      mem[dm_addr] <= dm_wdata;
    idle_q <= ~idle_q;
  end
  // idle data toggles so a stale value never passes for an answer
  assign dm_rdata = dm_en ? mem[dm_addr] : idle_q;
endmodule : pcs_dmem_model

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import pcs_pkg::*;
  logic core_clk, resetn, clk_en, fa_valid, fa_write, fa_rvalid, dm_en, dm_we;
  pcs_op_t op_kind;
  logic [10:0] op_target;
  logic [6:0] fa_addr;
  logic [7:0] fa_wdata, fa_rdata, dm_wdata, dm_rdata, awaddr, araddr, rd;
  logic [12:0] pc_out;
  logic [8:0] dm_addr, last_addr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rs;
  logic [1:0] bresp, rresp;
  int n_errors, total_checks, n_dm, pc, lath, sp, ptr;
  int stk [8];

  pcs_top u_dut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .op_kind(op_kind),
    .op_target(op_target), .fa_valid(fa_valid), .fa_write(fa_write), .fa_addr(fa_addr),
    .fa_wdata(fa_wdata), .fa_rvalid(fa_rvalid), .fa_rdata(fa_rdata), .pc_out(pc_out),
    .dm_en(dm_en), .dm_we(dm_we), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  pcs_dmem_model u_mem (.core_clk(core_clk), .dm_en(dm_en), .dm_we(dm_we), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_rdata(dm_rdata));

  // 100 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // memory strobes counted so refused accesses show up
  always @(posedge core_clk)
  begin
    if (dm_en === 1'b1)
    begin
      n_dm++;
      last_addr = dm_addr;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic results;
    if (n_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tmo;
    n_errors++;
    $display("[FAIL] %0t no answer", $time);
    results();
  endtask : tmo

  // reset also clears the reference state
  task automatic do_reset;
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    pc = 0;
    lath = 0;
    sp = 0;
    stk = '{default: 0};
    #1 chk(pc_out, 0);
  endtask : do_reset

  // one flow step, then the reference moves the same way
  task automatic do_op(input pcs_op_t k, input logic [10:0] t);
    @(posedge core_clk);
    op_kind <= k;
    op_target <= t;
    @(posedge core_clk);
    op_kind <= OP_NONE;
    case (k)
      OP_STEP: pc = (pc + 1) & 8191;
      OP_JUMP: pc = ((lath & 24) << 8) | t;
      OP_CALL:
      begin
        stk[sp] = (pc + 1) & 8191;
        sp = (sp + 1) & 7;
        pc = ((lath & 24) << 8) | t;
      end
      OP_INT:
      begin
        stk[sp] = pc;
        sp = (sp + 1) & 7;
        pc = 4;
      end
      default:
      begin
        sp = (sp - 1) & 7;
        pc = stk[sp];
      end
    endcase
    #1 chk(pc_out, pc);
  endtask : do_op

  task automatic fa_acc(input logic w, input logic [6:0] a, input logic [7:0] d);
    int i;
    @(posedge core_clk);
    fa_valid <= 1'b1;
    fa_write <= w;
    fa_addr <= a;
    fa_wdata <= d;
    @(posedge core_clk);
    fa_valid <= 1'b0;
    for (i = 0; i < 6; i++)
    begin
      @(posedge core_clk);
      if (fa_rvalid === 1'b1)
        break;
    end
    rd = fa_rdata;
    if (!w && i == 6)
      tmo();
    #1;
  endtask : fa_acc

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    logic aw_p, w_p;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge core_clk);
      if (aw_p && awready === 1'b1)
      begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready === 1'b1)
      begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1)
        break;
    end
    bready <= 1'b0;
    if (i == 40)
      tmo();
    chk(bresp, er);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int i;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge core_clk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
        break;
    end
    rready <= 1'b0;
    if (i == 40)
      tmo();
    chk(rresp, er);
    chk(rdata, ed);
  endtask : axi_rd

  initial
  begin
    {resetn, fa_valid, fa_write, awvalid, wvalid, bready, arvalid, rready} = '0;
    op_kind = OP_NONE;
    clk_en = 1'b1;
    {op_target, fa_addr, fa_wdata, awaddr, araddr, wdata} = '0;
    {n_errors, total_checks, n_dm} = '0;
    rs = 32'h03DF;
    do_reset();
    axi_rd(8'h28, 0, RESP_OKAY);
    axi_rd(8'h3C, 0, RESP_SLVERR);
    axi_wr(8'h00, 32'h55, RESP_SLVERR);
    rs = lfsr(rs);
    axi_wr(8'h28, rs, RESP_OKAY);
    lath = rs[4:0];
    axi_rd(8'h28, lath, RESP_OKAY);
    repeat (3) do_op(OP_STEP, 0);
    // a low enable freezes the counter although a step is asked for
    @(posedge core_clk);
    clk_en <= 1'b0;
    op_kind <= OP_STEP;
    repeat (3) @(posedge core_clk);
    op_kind <= OP_NONE;
    clk_en <= 1'b1;
    #1 chk(pc_out, pc);
    rs = lfsr(rs);
    do_op(OP_JUMP, rs[10:0]);
    // nine calls wrap the stack; unwinding uses every return kind
    for (int i = 0; i < 9; i++)
    begin
      rs = lfsr(rs);
      do_op(OP_CALL, rs[10:0]);
    end
    for (int i = 0; i < 9; i++)
      do_op(pcs_op_t'(i % 3 == 0 ? OP_RET : (i % 3 == 1 ? OP_EXIT_LIT : OP_EXIT_INT)), 0);
    do_op(OP_INT, 0);
    do_op(OP_EXIT_INT, 0);
    // call and return on adjacent edges hand back the next address
    @(posedge core_clk);
    op_kind <= OP_CALL;
    op_target <= rs[10:0];
    @(posedge core_clk);
    op_kind <= OP_RET;
    @(posedge core_clk);
    op_kind <= OP_NONE;
    stk[sp] = (pc + 1) & 8191;
    pc = stk[sp];
    #1 chk(pc_out, pc);
    axi_rd(8'h28, lath, RESP_OKAY);
    // low byte write near a block end, as table software must mind
    rs = lfsr(rs);
    fa_acc(1'b1, IDX_LOW, rs[7:0]);
    pc = (lath << 8) | rs[7:0];
    chk(pc_out, pc);
    fa_acc(1'b0, IDX_LOW, 0);
    chk(rd, pc & 255);
    axi_rd(8'h08, pc & 255, RESP_OKAY);
    fa_acc(1'b1, IDX_LATH, 8'h1F);
    lath = 31;
    fa_acc(1'b1, IDX_LOW, 8'hFF);
    pc = 8191;
    chk(pc_out, pc);
    do_op(OP_STEP, 0);
    // indirect traffic through the pointer, then through the port itself
    ptr = 37;
    fa_acc(1'b1, IDX_FSEL, ptr);
    fa_acc(1'b1, IDX_IND, 8'hA5);
    chk(last_addr, ptr);
    fa_acc(1'b0, IDX_IND, 0);
    chk(rd, 8'hA5);
    chk(n_dm, 2);
    for (int j = 0; j < 2; j++)
    begin
      ptr = j ? 128 : 0;
      fa_acc(1'b1, IDX_FSEL, ptr);
      fa_acc(1'b1, IDX_IND, 8'h3C);
      fa_acc(1'b0, IDX_IND, 0);
      chk(rd, 0);
      chk(n_dm, 2);
    end
    do_op(OP_STEP, 0);
    do_reset();
    results();
  end
endmodule : testbench
